// ==== hw/cmf_mask_filter.sv ====
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
module cmf_mask_filter
    import cmf_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [cmf_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [cmf_pkg::DAT_W-1:0] wb_dat_i,
    input  wire logic [3:0]             wb_sel_i,
    output logic      [cmf_pkg::DAT_W-1:0] wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   init_acknowledge_i,
    output logic                        init_request_o,
    input  wire cmf_pkg::cmf_pair_t     accept_code_bits_i,
    input  wire cmf_pkg::cmf_rx_id_t    rx_identifier_byte_i,
    output logic                        rx_accept_o,
    output logic                        rx_drop_o,
    output logic      [1:0]             rx_bank_hit_o
);
    import cmf_pkg::*;

    cmf_bus_state_t           state_reg;
    logic [DAT_W-1:0]         dat_reg;
    logic [DAT_W-1:0]         dat_next;
    logic [7:0]               mask_reg [8];
    logic                     init_request_reg;
    logic [5:0]               idx;
    logic [3:0]               slot;
    logic                     req;
    logic                     fire_wr;
    logic                     init_mode;
    cmf_pair_t                mask_pair;
    logic [1:0]               bank_hit;
    cmf_result_t              pulse;
    cmf_result_t              last;

    assign idx       = wb_adr_i[ADR_W-1:2];
    assign slot      = cmf_mask_slot(idx);
    assign req       = wb_cyc_i & wb_stb_i;
    assign init_mode = init_request_reg & init_acknowledge_i;
    // A write lands at the edge where the master sees ack high.
    assign fire_wr   = (state_reg == CMF_ACK) & req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= CMF_IDLE;
        end else begin
            case (state_reg)
                CMF_IDLE: begin
                    if (req) begin
                        state_reg <= CMF_ACK;
                    end
                end
                CMF_ACK: begin
                    state_reg <= CMF_IDLE;
                end
                default: begin
                    state_reg <= CMF_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        dat_next = '0;
        if (slot[3]) begin
            dat_next[7:0] = mask_reg[slot[2:0]];
        end else if (idx == IDX_CTRL) begin
            dat_next[CTRL_INIT_REQUEST_BIT] = init_request_reg;
            dat_next[CTRL_INIT_ACKNOWLEDGE_BIT] = init_acknowledge_i;
        end else if (idx == IDX_STAT) begin
            dat_next[STAT_ACCEPT_BIT] = last.accept;
            dat_next[STAT_DROP_BIT]   = last.drop;
            dat_next[STAT_HIT0_BIT]   = last.bank_hit[0];
            dat_next[STAT_HIT1_BIT]   = last.bank_hit[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= '0;
        end else if (state_reg == CMF_IDLE && req && !wb_we_i) begin
            dat_reg <= dat_next;
        end
    end

    // Mask writes outside initialization mode are acked but discarded.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                mask_reg[i] <= MASK_RST;
            end
        end else if (fire_wr && slot[3] && init_mode) begin
            mask_reg[slot[2:0]] <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_request_reg <= INIT_REQUEST_RST;
        end else if (fire_wr && idx == IDX_CTRL) begin
            init_request_reg <= wb_dat_i[CTRL_INIT_REQUEST_BIT];
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            mask_pair.bank0[i] = mask_reg[i];
            mask_pair.bank1[i] = mask_reg[i+4];
        end
    end

    // Two banks side by side; a hit in either accepts the message.
    cmf_bank_match u_bank0 (
        .id_i       (rx_identifier_byte_i.id),
        .code_i     (accept_code_bits_i.bank0),
        .mask_i     (mask_pair.bank0),
        .extended_i (rx_identifier_byte_i.extended),
        .hit_o      (bank_hit[0])
    );

    cmf_bank_match u_bank1 (
        .id_i       (rx_identifier_byte_i.id),
        .code_i     (accept_code_bits_i.bank1),
        .mask_i     (mask_pair.bank1),
        .extended_i (rx_identifier_byte_i.extended),
        .hit_o      (bank_hit[1])
    );

    cmf_decide u_decide (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .valid_i (rx_identifier_byte_i.valid),
        .hit_i   (bank_hit),
        .pulse_o (pulse),
        .last_o  (last)
    );

    assign wb_ack_o       = (state_reg == CMF_ACK);
    assign wb_dat_o       = dat_reg;
    assign init_request_o = init_request_reg;
    assign rx_accept_o    = pulse.accept;
    assign rx_drop_o      = pulse.drop;
    assign rx_bank_hit_o  = pulse.bank_hit;

    // Independent reference for both banks using bitwise terms only.
    logic [31:0] chk_miss0;
    logic        chk_hit0;
    logic        chk_hit1;
    logic [31:0] chk_miss1;
    assign chk_miss0 = (rx_identifier_byte_i.id ^ accept_code_bits_i.bank0)
                       & ~mask_pair.bank0;
    assign chk_miss1 = (rx_identifier_byte_i.id ^ accept_code_bits_i.bank1)
                       & ~mask_pair.bank1;
    assign chk_hit0  = rx_identifier_byte_i.extended ? (chk_miss0 == '0)
                       : (chk_miss0[15:0] == '0);
    assign chk_hit1  = rx_identifier_byte_i.extended ? (chk_miss1 == '0)
                       : (chk_miss1[15:0] == '0);

    property p_relevant_mismatch;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid && (chk_miss0[7:0] != 8'h00)
            && (chk_miss1[7:0] != 8'h00) |=> rx_drop_o && !rx_accept_o;
    endproperty
    a_relevant_mismatch: assert property (p_relevant_mismatch)
        else $error("Relevant bit mismatch did not drop message.");

    property p_accept_all;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid |=>
            rx_accept_o == ($past(chk_hit0) || $past(chk_hit1));
    endproperty
    a_accept_all: assert property (p_accept_all)
        else $error("Accept decision differs from reference.");

    property p_ignore_set;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid && (mask_pair.bank0 == '1) |=> rx_accept_o;
    endproperty
    a_ignore_set: assert property (p_ignore_set)
        else $error("Fully masked bank did not accept.");

    property p_no_write_outside_init;
        @(posedge clk_i) disable iff (rst_i)
        fire_wr && slot[3] && !init_mode |=>
            mask_reg[$past(slot[2:0])] == $past(mask_reg[slot[2:0]]);
    endproperty
    a_no_write_outside_init: assert property (p_no_write_outside_init)
        else $error("Mask changed outside initialization mode.");

    property p_write_in_init;
        @(posedge clk_i) disable iff (rst_i)
        fire_wr && slot[3] && init_mode |=>
            mask_reg[$past(slot[2:0])] == $past(wb_dat_i[7:0]);
    endproperty
    a_write_in_init: assert property (p_write_in_init)
        else $error("Mask write in initialization mode lost.");

    property p_read_any_time;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == CMF_IDLE && req && !wb_we_i && slot[3] |=>
            wb_ack_o && wb_dat_o[7:0] == $past(mask_reg[slot[2:0]])
            && wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_read_any_time: assert property (p_read_any_time)
        else $error("Mask read returned wrong data.");

    property p_standard_two_pairs;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid && !rx_identifier_byte_i.extended
            && (chk_miss0[15:0] == 16'h0000 || chk_miss1[15:0] == 16'h0000)
            |=> rx_accept_o;
    endproperty
    a_standard_two_pairs: assert property (p_standard_two_pairs)
        else $error("Standard frame judged on upper byte pairs.");

    property p_one_outcome;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid |=> (rx_accept_o ^ rx_drop_o);
    endproperty
    a_one_outcome: assert property (p_one_outcome)
        else $error("Message neither or both accepted and dropped.");

    property p_idle_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !rx_identifier_byte_i.valid |=> !rx_accept_o && !rx_drop_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Outcome pulse without a message.");

    property p_reset_zero;
        @(posedge clk_i)
        rst_i |=> mask_reg[0] == MASK_RST && mask_reg[7] == MASK_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Mask not cleared by reset.");

    property p_ack_one_cycle;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("Ack held longer than one cycle.");

    c_write_init: cover property (@(posedge clk_i) disable iff (rst_i)
        fire_wr && slot[3] && init_mode);
    c_write_refused: cover property (@(posedge clk_i) disable iff (rst_i)
        fire_wr && slot[3] && !init_mode);
    c_accept_ext: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid && rx_identifier_byte_i.extended
        ##1 rx_accept_o);
    c_drop: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_drop_o);
    c_accept_std: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid && !rx_identifier_byte_i.extended
        ##1 rx_accept_o);

    property p_sel_gate;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == CMF_ACK) && req && wb_we_i && !wb_sel_i[0] && slot[3]
            |=> mask_reg[$past(slot[2:0])] == $past(mask_reg[slot[2:0]]);
    endproperty
    a_sel_gate: assert property (p_sel_gate)
        else $error("Mask write without low byte enable landed.");

    // Masks may only move on an accepted write in initialization mode.
    property p_mask_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(fire_wr && slot[3] && init_mode) |=> $stable(mask_pair);
    endproperty
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("Mask changed without an accepted write.");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        fire_wr && idx == IDX_CTRL |=>
            init_request_o == $past(wb_dat_i[CTRL_INIT_REQUEST_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Init request write lost.");

    property p_hit_ref;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid |=>
            rx_bank_hit_o == $past({chk_hit1, chk_hit0});
    endproperty
    a_hit_ref: assert property (p_hit_ref)
        else $error("Bank hit differs from reference.");

    // Software polls the status copy, so it must equal the pulse it mirrors.
    property p_status_copy;
        @(posedge clk_i) disable iff (rst_i)
        rx_identifier_byte_i.valid |=> last == pulse;
    endproperty
    a_status_copy: assert property (p_status_copy)
        else $error("Status copy differs from outcome pulse.");

    property p_ack_latency;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == CMF_IDLE && req |=> wb_ack_o;
    endproperty
    a_ack_latency: assert property (p_ack_latency)
        else $error("Bus request not answered in one cycle.");
endmodule

// ==== hw/cmf_pkg.sv ====
package cmf_pkg;

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_MASK_B0_0 = 6'h14;
    localparam logic [5:0] IDX_MASK_B0_1 = 6'h15;
    localparam logic [5:0] IDX_MASK_B0_2 = 6'h16;
    localparam logic [5:0] IDX_MASK_B0_3 = 6'h17;
    localparam logic [5:0] IDX_MASK_B1_0 = 6'h1C;
    localparam logic [5:0] IDX_MASK_B1_1 = 6'h1D;
    localparam logic [5:0] IDX_MASK_B1_2 = 6'h1E;
    localparam logic [5:0] IDX_MASK_B1_3 = 6'h1F;
    localparam logic [5:0] IDX_CTRL      = 6'h20;
    localparam logic [5:0] IDX_STAT      = 6'h21;

    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic       INIT_REQUEST_RST = 1'b0;

    localparam int CTRL_INIT_REQUEST_BIT = 0;
    localparam int CTRL_INIT_ACKNOWLEDGE_BIT = 1;
    localparam int STAT_ACCEPT_BIT = 0;
    localparam int STAT_DROP_BIT   = 1;
    localparam int STAT_HIT0_BIT   = 2;
    localparam int STAT_HIT1_BIT   = 3;
    localparam int STAT_W          = 4;

    typedef logic [3:0][7:0] cmf_bank_t;

    typedef struct packed {
        cmf_bank_t bank1;
        cmf_bank_t bank0;
    } cmf_pair_t;

    typedef struct packed {
        logic      valid;
        logic      extended;
        cmf_bank_t id;
    } cmf_rx_id_t;

    typedef struct packed {
        logic       accept;
        logic       drop;
        logic [1:0] bank_hit;
    } cmf_result_t;

    typedef enum logic [0:0] {
        CMF_IDLE = 1'b0,
        CMF_ACK  = 1'b1
    } cmf_bus_state_t;

    // One byte matches when every bit with a clear mask equals its code bit.
    function automatic logic cmf_byte_hit(input logic [7:0] id,
                                          input logic [7:0] code,
                                          input logic [7:0] mask);
        cmf_byte_hit = &(~(id ^ code) | mask);
    endfunction

    // Returns {valid, bank, byte[1:0]} for a mask register index.
    function automatic logic [3:0] cmf_mask_slot(input logic [5:0] idx);
        cmf_mask_slot = 4'h0;
        if (idx >= IDX_MASK_B0_0 && idx <= IDX_MASK_B0_3) begin
            cmf_mask_slot = {2'b10, idx[1:0]};
        end else if (idx >= IDX_MASK_B1_0 && idx <= IDX_MASK_B1_3) begin
            cmf_mask_slot = {2'b11, idx[1:0]};
        end
    endfunction

endpackage

// ==== hw/cmf_bank_match.sv ====
`timescale 1ns/10ps
module cmf_bank_match
    import cmf_pkg::*;
(
    input  wire cmf_pkg::cmf_bank_t id_i,
    input  wire cmf_pkg::cmf_bank_t code_i,
    input  wire cmf_pkg::cmf_bank_t mask_i,
    input  wire logic               extended_i,
    output logic                    hit_o
);
    logic [3:0] byte_hit;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byte_hit[i] = cmf_byte_hit(id_i[i], code_i[i], mask_i[i]);
        end
    end

    // Standard frames use only the first two byte pairs.
    assign hit_o = extended_i ? &byte_hit : &byte_hit[1:0];
endmodule

// ==== hw/cmf_decide.sv ====
`timescale 1ns/10ps
module cmf_decide
    import cmf_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                valid_i,
    input  wire logic [1:0]          hit_i,
    output cmf_pkg::cmf_result_t     pulse_o,
    output cmf_pkg::cmf_result_t     last_o
);
    cmf_result_t pulse_reg;
    cmf_result_t last_reg;
    cmf_result_t res_next;

    always_comb begin
        res_next.accept   = valid_i & (|hit_i);
        res_next.drop     = valid_i & ~(|hit_i);
        res_next.bank_hit = valid_i ? hit_i : 2'b00;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_reg <= '0;
        end else begin
            pulse_reg <= res_next;
        end
    end

    // The status copy holds until the next message so software can poll it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_reg <= '0;
        end else if (valid_i) begin
            last_reg <= res_next;
        end
    end

    assign pulse_o = pulse_reg;
    assign last_o  = last_reg;
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
    import cmf_pkg::*;

    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [31:0] dat    = 32'h0;
    logic [3:0]  sel    = 4'h0;
    logic        ack_in = 1'b0;
    cmf_pair_t   code   = '{bank1: 32'h9ABCDEF0, bank0: 32'h12345678};
    cmf_rx_id_t  rx_id  = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        init_request_o;
    logic        rx_accept_o;
    logic        rx_drop_o;
    logic [1:0]  rx_bank_hit_o;
    logic [7:0]  m_exp [2][4];
    logic        req_exp = 1'b0;
    int          failures = 0;
    int          compares = 0;

    always #4 clk_i = ~clk_i;

    cmf_mask_filter i_cmf_mask_filter (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .wb_cyc_i             (cyc),
        .wb_stb_i             (stb),
        .wb_we_i              (we),
        .wb_adr_i             (adr),
        .wb_dat_i             (dat),
        .wb_sel_i             (sel),
        .wb_dat_o             (wb_dat_o),
        .wb_ack_o             (wb_ack_o),
        .init_acknowledge_i   (ack_in),
        .init_request_o       (init_request_o),
        .accept_code_bits_i   (code),
        .rx_identifier_byte_i (rx_id),
        .rx_accept_o          (rx_accept_o),
        .rx_drop_o            (rx_drop_o),
        .rx_bank_hit_o        (rx_bank_hit_o)
    );

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    // Ack is judged on the edge value, so data is taken where it is valid.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr_mask(input int b, input int n, input logic [7:0] v,
                           input logic [3:0] s);
        logic [31:0] rd;
        wb(1'b1, (b != 0 ? 8'h70 : 8'h50) + 8'(4 * n), {24'hFFFFFF, v}, s,
           rd);
        if (req_exp && ack_in && s[0]) begin
            m_exp[b][n] = v;
        end
    endtask

    task automatic rd_all();
        logic [31:0] rd;
        for (int b = 0; b < 2; b++) begin
            for (int n = 0; n < 4; n++) begin
                wb(1'b0, (b != 0 ? 8'h70 : 8'h50) + 8'(4 * n), 32'h0, 4'hF,
                   rd);
                check(rd, {24'h0, m_exp[b][n]}, "mask readback");
            end
        end
    endtask

    task automatic set_ctrl(input logic v);
        logic [31:0] rd;
        wb(1'b1, 8'h80, {31'h0, v}, 4'h1, rd);
        req_exp = v;
        // The register updates at the ack edge, so look one edge later.
        @(posedge clk_i);
        check({31'h0, init_request_o}, {31'h0, v}, "init request");
    endtask

    function automatic logic bank_ok(cmf_bank_t id, cmf_bank_t c, int b,
                                     logic ext);
        logic ok = 1'b1;
        for (int n = 0; n < (ext ? 4 : 2); n++) begin
            for (int k = 0; k < 8; k++) begin
                if (!m_exp[b][n][k] && id[n][k] !== c[n][k]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    task automatic check_res(input logic [1:0] h);
        check({rx_accept_o, rx_drop_o, rx_bank_hit_o}, {|h, ~|h, h},
              "filter result");
    endtask

    // Two messages on consecutive edges, then the status of the second.
    task automatic send_pair(input cmf_bank_t ia, input logic ea,
                             input cmf_bank_t ib, input logic eb);
        logic [1:0]  ha;
        logic [1:0]  hb;
        logic [31:0] rd;
        ha = {bank_ok(ia, code.bank1, 1, ea), bank_ok(ia, code.bank0, 0, ea)};
        hb = {bank_ok(ib, code.bank1, 1, eb), bank_ok(ib, code.bank0, 0, eb)};
        @(posedge clk_i);
        rx_id <= '{valid: 1'b1, extended: ea, id: ia};
        @(posedge clk_i);
        rx_id <= '{valid: 1'b1, extended: eb, id: ib};
        @(posedge clk_i);
        rx_id.valid <= 1'b0;
        check_res(ha);
        @(posedge clk_i);
        check_res(hb);
        @(posedge clk_i);
        check({30'h0, rx_accept_o, rx_drop_o}, 32'h0, "pulse length");
        wb(1'b0, 8'h84, 32'h0, 4'hF, rd);
        check(rd, {28'h0, hb, ~|hb, |hb}, "status");
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        for (int i = 0; i < 8; i++) begin
            m_exp[i / 4][i % 4] = 8'h00;
        end
        rd_all();
        wb(1'b0, 8'h80, 32'h0, 4'hF, rd);
        check(rd, 32'h0, "ctrl after reset");
    endtask

    task automatic t_mode();
        logic [31:0] rd;
        wr_mask(0, 0, 8'hA5, 4'h1);
        set_ctrl(1'b1);
        wr_mask(1, 3, 8'h5A, 4'h1);
        rd_all();
        @(posedge clk_i);
        ack_in <= 1'b1;
        wb(1'b0, 8'h80, 32'h0, 4'hF, rd);
        check(rd, 32'h3, "ctrl in init");
        for (int i = 0; i < 8; i++) begin
            wr_mask(i / 4, i % 4, 8'h11 * 8'(i + 1), 4'h1);
        end
        wr_mask(0, 2, 8'hEE, 4'hE);
        rd_all();
        wb(1'b0, 8'h40, 32'h0, 4'hF, rd);
        check(rd, 32'h0, "unmapped read");
        set_ctrl(1'b0);
        wr_mask(0, 1, 8'hFF, 4'h1);
        @(posedge clk_i);
        ack_in <= 1'b0;
        wr_mask(1, 1, 8'hFF, 4'h1);
        rd_all();
    endtask

    task automatic t_filter();
        set_ctrl(1'b1);
        @(posedge clk_i);
        ack_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr_mask(i / 4, i % 4, 8'h00, 4'h1);
        end
        send_pair(code.bank0, 1'b1, code.bank0 ^ 32'h01000000, 1'b1);
        wr_mask(0, 3, 8'h01, 4'h1);
        send_pair(code.bank0 ^ 32'h01000000, 1'b1,
                  code.bank1 ^ 32'h00FF0000, 1'b0);
        send_pair(code.bank1 ^ 32'h00FF0000, 1'b1,
                  32'hFFFFFFFF, 1'b0);
        wr_mask(0, 1, 8'h07, 4'h1);
        wr_mask(1, 1, 8'h07, 4'h1);
        send_pair(code.bank1 ^ 32'h00000500, 1'b0,
                  code.bank1 ^ 32'h00000800, 1'b0);
        for (int n = 0; n < 4; n++) begin
            wr_mask(0, n, 8'hFF, 4'h1);
        end
        send_pair(32'h00000000, 1'b1, 32'hFFFFFFFF, 1'b0);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({31'h0, init_request_o}, 32'h0, "reset request");
        t_reset();
        t_mode();
        t_filter();
        close_out();
    end
endmodule
